// ===== pkg/tps_consts.svh
// constants of the two-rail power sequencer: register offsets, fields,
// reset values and timing counts; assumes a 125 MHz core clock.
//
// How it works
// [RULE_01] mode pin high selects pure time delay, low selects power-good sequencing
// [RULE_02] sequencing delay resets to 6 ms until software reprograms it
// [RULE_03] time mode soft start lasts two thirds of the programmed delay
// [RULE_04] programmed delay is held within 3 ms to 16 ms
// [RULE_05] nothing starts until the activate input goes high
// [RULE_06] step outputs float high when released; pins read high if unconnected
// [RULE_07] time mode: soft start, then remaining delay, then next enable rises
// [RULE_08] power-good mode rails use a fixed 4 ms soft start
// [RULE_09] power-good mode: delay starts at first rail good, then next enable
// [RULE_10] order pin high: regulator one first; low: regulator four first
// [RULE_11] board wires first step output to regulator one, second to four
// [RULE_12] board holds order pin high in time mode
// [RULE_13] activate low holds both enables low and clears the timer
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

`define TPS_CLK_KHZ        125000
`define TPS_TICKS_PER_MS   3
`define TPS_TICK_CYC       ((`TPS_CLK_KHZ + `TPS_TICKS_PER_MS - 1) / `TPS_TICKS_PER_MS)

`define TPS_DELAY_DEF_MS   5'h06
`define TPS_DELAY_MIN_MS   5'h03
`define TPS_DELAY_MAX_MS   5'h10
`define TPS_PG_SOFT_MS     6'h04

`define TPS_OFF_DELAY      12'h000
`define TPS_OFF_STATUS     12'h004

`define TPS_ST_STATE_LSB   0
`define TPS_ST_MODE_BIT    2
`define TPS_ST_ORDER_BIT   3
`define TPS_ST_EN1_BIT     4
`define TPS_ST_EN4_BIT     5
`define TPS_ST_PG1_BIT     6
`define TPS_ST_PG4_BIT     7
`define TPS_ST_SOFT_BIT    8

`endif

// ===== pkg/tps_pkg.sv
// types shared by the sequencer files
// assumes the constants header is included by each user
package tps_pkg;
  typedef enum logic [1:0] {
    TPS_IDLE     = 2'b00,
    TPS_FIRST    = 2'b01,
    TPS_PG_DELAY = 2'b10,
    TPS_DONE     = 2'b11
  } tps_state_e;
endpackage : tps_pkg

// ===== rtl/tps_tick_timer.sv
// elapsed-time counter in thirds of a millisecond
// assumes run is a registered level from the sequencer
`timescale 1ns/100ps
module tps_tick_timer #(
  parameter int TICK_CYC = 41667
) (
  input  wire logic       core_clk, // core clock
  input  wire logic       rst_n,    // synchronous reset
  input  wire logic       run,      // count while high, clear while low
  output logic      [5:0] elapsed   // elapsed ticks, saturating
);
  logic [16:0] presc;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      presc <= 17'h00000;
    end else if (presc == 17'(TICK_CYC - 1)) begin
      presc <= 17'h00000;
    end else begin
      presc <= presc + 17'h00001;
    end
  end

  // saturation keeps a long stall from wrapping back below a target
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      elapsed <= 6'h00;
    end else if (presc == 17'(TICK_CYC - 1) && elapsed != 6'h3F) begin
      elapsed <= elapsed + 6'h01;
    end
  end
endmodule : tps_tick_timer

// ===== rtl/tps_sequencer.sv
// two-rail power sequencer with an apb register slave
// assumes pins are resolved levels (pull-ups applied outside) and
// synchronous to core_clk
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "tps_consts.svh"
module tps_sequencer #(
  parameter int TICK_CYC = `TPS_TICK_CYC
) (
  input  wire logic               core_clk,               // 125 MHz
  input  wire logic               rst_n,                  // sync reset
  input  wire logic               psel,                   // apb select
  input  wire logic               penable,                // apb access
  input  wire logic               pwrite,                 // apb write
  input  wire logic [11:0]        paddr,                  // byte address
  input  wire logic [31:0]        pwdata,                 // write data
  output logic      [31:0]        prdata,                 // read data
  output logic                    pready,                 // apb ready
  output logic                    pslverr,                // unmapped
  input  wire logic               mode_select,            // 1 time, 0 pg
  input  wire logic               rail_order_select,      // order pin
  input  wire logic               seq_activate,           // start level
  input  wire logic               regulator_one_power_good, // rail 1 good
  input  wire logic               regulator_four_power_good, // rail 4 good
  output logic                    regulator_one_enable,   // rail 1 enable
  output logic                    regulator_four_enable,  // rail 4 enable
  output logic                    first_step_enable_out,  // step 1 level
  output logic                    first_step_enable_oe,   // drive low
  output logic                    second_step_enable_out, // step 2 level
  output logic                    second_step_enable_oe,  // drive low
  output logic      [5:0]         soft_start_ticks,       // rail soft start
  output tps_pkg::tps_state_e     seq_state               // sequencer state
);
  import tps_pkg::*;

  logic [4:0] delay_ms;
  logic       mode_lat;
  logic       order_lat;
  logic       first_en;
  logic       second_en;
  logic       timer_run;
  logic [5:0] elapsed;
  logic [5:0] delay_ticks;
  logic [5:0] soft_ticks;
  logic       soft_done;
  logic       pg_first;
  logic       wr_en;
  logic       rd_en;
  logic [4:0] wr_ms;
  logic [4:0] next_delay;
  tps_state_e next_state;

  assign delay_ticks = {1'b0, delay_ms} + {delay_ms, 1'b0} - {1'b0, delay_ms}
                       + {1'b0, delay_ms};
  assign soft_ticks  = {delay_ms, 1'b0};                             // RULE_03
  assign soft_done   = elapsed >= soft_ticks;
  assign pg_first    = order_lat ? regulator_one_power_good
                                 : regulator_four_power_good;       // RULE_10
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;
  assign wr_ms = pwdata[4:0];

  tps_tick_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (timer_run),
    .elapsed  (elapsed)
  );

  // out-of-range writes clamp rather than fault, so a bad value never
  // leaves the rails with an unusable step time
  always_comb begin
    next_delay = delay_ms;
    if (wr_en && paddr == `TPS_OFF_DELAY) begin
      if (wr_ms < `TPS_DELAY_MIN_MS) begin
        next_delay = `TPS_DELAY_MIN_MS;                             // RULE_04
      end else if (wr_ms > `TPS_DELAY_MAX_MS) begin
        next_delay = `TPS_DELAY_MAX_MS;                             // RULE_04
      end else begin
        next_delay = wr_ms;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      delay_ms <= `TPS_DELAY_DEF_MS;                                // RULE_02
    end else begin
      delay_ms <= next_delay;
    end
  end

  // sequence state
  always_comb begin
    next_state = seq_state;
    case (seq_state)
      TPS_IDLE: begin
        if (seq_activate) begin
          next_state = TPS_FIRST;                                   // RULE_05
        end
      end
      TPS_FIRST: begin
        if (mode_lat && elapsed >= delay_ticks) begin
          next_state = TPS_DONE;                                    // RULE_07
        end else if (!mode_lat && pg_first) begin
          next_state = TPS_PG_DELAY;                                // RULE_09
        end
      end
      TPS_PG_DELAY: begin
        if (elapsed >= delay_ticks) begin
          next_state = TPS_DONE;                                    // RULE_09
        end
      end
      default: begin
        next_state = TPS_DONE;
      end
    endcase
    if (!seq_activate) begin
      next_state = TPS_IDLE;                                        // RULE_13
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_state <= TPS_IDLE;
    end else begin
      seq_state <= next_state;
    end
  end

  // mode and order are caught at start so a pin glitch mid-sequence
  // cannot swap rails under power
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_lat  <= 1'b1;
      order_lat <= 1'b1;
    end else if (seq_state == TPS_IDLE) begin
      mode_lat  <= mode_select;                                     // RULE_01
      order_lat <= rail_order_select;                               // RULE_10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_en  <= 1'b0;
      second_en <= 1'b0;
      timer_run <= 1'b0;
    end else begin
      first_en  <= next_state != TPS_IDLE;                          // RULE_13
      second_en <= next_state == TPS_DONE;
      timer_run <= (next_state == TPS_FIRST && mode_select_eff(next_state))
                   || next_state == TPS_PG_DELAY;                   // RULE_09
    end
  end

  function automatic logic mode_select_eff(input tps_state_e ns);
    mode_select_eff = (seq_state == TPS_IDLE) ? mode_select : mode_lat;
  endfunction : mode_select_eff

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regulator_one_enable  <= 1'b0;
      regulator_four_enable <= 1'b0;
    end else begin
      regulator_one_enable  <= (next_state != TPS_IDLE) &&
        (((seq_state == TPS_IDLE) ? rail_order_select : order_lat)
         || next_state == TPS_DONE);                                // RULE_10
      regulator_four_enable <= (next_state != TPS_IDLE) &&
        (!((seq_state == TPS_IDLE) ? rail_order_select : order_lat)
         || next_state == TPS_DONE);                                // RULE_10
    end
  end

  // step outputs pull low while off and release to the pull-up when on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_step_enable_out  <= 1'b0;
      first_step_enable_oe   <= 1'b1;
      second_step_enable_out <= 1'b0;
      second_step_enable_oe  <= 1'b1;
    end else begin
      first_step_enable_out  <= next_state != TPS_IDLE;
      first_step_enable_oe   <= next_state == TPS_IDLE;             // RULE_06
      second_step_enable_out <= next_state == TPS_DONE;
      second_step_enable_oe  <= next_state != TPS_DONE;             // RULE_06
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      soft_start_ticks <= 6'h00;
    end else if (mode_select_eff(next_state)) begin
      soft_start_ticks <= {next_delay, 1'b0};                       // RULE_03
    end else begin
      soft_start_ticks <= 6'(`TPS_PG_SOFT_MS * `TPS_TICKS_PER_MS);  // RULE_08
    end
  end

  // apb: three-cycle access (one wait state), ready raised by the slave one cycle into the access phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready &&
                 paddr != `TPS_OFF_DELAY && paddr != `TPS_OFF_STATUS;
      if (rd_en && paddr == `TPS_OFF_DELAY) begin
        prdata <= {27'h0000000, delay_ms};
      end else if (rd_en && paddr == `TPS_OFF_STATUS) begin
        prdata <= {23'h000000, soft_done && timer_run,
                   regulator_four_power_good, regulator_one_power_good,
                   regulator_four_enable, regulator_one_enable,
                   order_lat, mode_lat, seq_state};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // checks
  logic no_write_yet;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      no_write_yet <= 1'b1;
    end else if (wr_en && paddr == `TPS_OFF_DELAY) begin
      no_write_yet <= 1'b0;
    end
  end

  sequence s_pg_good;
    seq_state == TPS_FIRST && !mode_lat && pg_first && seq_activate;
  endsequence

  sequence s_pg_wait;
    seq_state == TPS_PG_DELAY && !second_step_enable_out && timer_run;
  endsequence

  a_delay_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    no_write_yet |-> delay_ms == `TPS_DELAY_DEF_MS) // RULE_02
    else $error("delay not at default");

  a_delay_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    delay_ms >= `TPS_DELAY_MIN_MS && delay_ms <= `TPS_DELAY_MAX_MS) // RULE_04
    else $error("delay out of range");

  a_soft_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state != TPS_IDLE && mode_lat && $stable(delay_ms)
    |-> soft_start_ticks == {delay_ms, 1'b0}) // RULE_03
    else $error("time soft start not two thirds");

  a_soft_pg: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state != TPS_IDLE && !mode_lat |-> soft_start_ticks == 6'h0C) // RULE_08
    else $error("pg soft start not 4 ms");

  a_idle_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !seq_activate |=> !regulator_one_enable && !regulator_four_enable
                      && !timer_run && seq_state == TPS_IDLE
                      ##1 elapsed == 6'h00) // RULE_13
    else $error("enables not held low");

  a_start_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state == TPS_IDLE && seq_activate
    |=> regulator_one_enable == $past(rail_order_select)
        && regulator_four_enable != $past(rail_order_select)) // RULE_10
    else $error("wrong first rail");

  a_time_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state == TPS_FIRST && mode_lat && seq_activate
    && elapsed >= delay_ticks |=> second_step_enable_out
    && regulator_one_enable && regulator_four_enable) // RULE_07
    else $error("second rail late in time mode");

  a_time_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state == TPS_FIRST && mode_lat && elapsed < delay_ticks
    |-> !second_step_enable_out) // RULE_07
    else $error("second rail early");

  a_pg_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_pg_good |=> s_pg_wait) // RULE_09
    else $error("pg delay not started");

  a_pg_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_state == TPS_FIRST && !mode_lat && !pg_first && seq_activate
    |=> seq_state == TPS_FIRST && !second_step_enable_out) // RULE_01
    else $error("pg mode moved without good");
endmodule : tps_sequencer

// ===== verification/tps_rail_model.sv
// behavioural buck rail: power good follows enable after a settle time
// assumes enable is a resolved level synchronous to core_clk
`timescale 1ns/100ps
module tps_rail_model #(
  parameter int PG_CYC = 20
) (
  input  wire logic core_clk,   // bench clock
  input  wire logic rst_n,      // sync reset
  input  wire logic enable,     // rail enable level
  output logic      power_good  // rail good level
);
  int cnt;

  // good only after the ramp; losing enable drops it at once
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      cnt        <= 0;
      power_good <= 1'b0;
    end else if (cnt == PG_CYC) begin
      power_good <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tps_rail_model

// ===== verification/two_rail_power_sequencer_tb_top.sv
// self-checking bench for the two-rail sequencer: apb tasks, two rails
// assumes the shortened tick so a millisecond is 3 * TICK cycles
`timescale 1ns/100ps
`include "tps_consts.svh"
module two_rail_power_sequencer_tb_top;
  import tps_pkg::*;
  localparam int TICK = 4;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e;
  logic        mode_select = 1'b1, rail_order_select = 1'b1;
  logic        seq_activate = 1'b0, pg1, pg4, en1, en4;
  logic        s1_out, s1_oe, s2_out, s2_oe;
  logic [5:0]  soft_ticks;
  tps_state_e  seq_state;
  int          num_errors = 0, checks = 0, cyc = 0, n;
  logic [31:0] wr_v[3] = '{32'h2, 32'h11, 32'h3};
  logic [31:0] ex_v[3] = '{32'h3, 32'h10, 32'h3};
  // released step pins are pulled high
  wire step1_pin = s1_oe ? 1'b0 : 1'b1;
  wire step2_pin = s2_oe ? 1'b0 : 1'b1;
  wire rail1_en = mode_select ? step1_pin : en1;
  wire rail4_en = mode_select ? step2_pin : en4;

  tps_sequencer #(.TICK_CYC(TICK)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_select(mode_select),
    .rail_order_select(rail_order_select), .seq_activate(seq_activate),
    .regulator_one_power_good(pg1), .regulator_four_power_good(pg4),
    .regulator_one_enable(en1), .regulator_four_enable(en4),
    .first_step_enable_out(s1_out), .first_step_enable_oe(s1_oe),
    .second_step_enable_out(s2_out), .second_step_enable_oe(s2_oe),
    .soft_start_ticks(soft_ticks), .seq_state(seq_state));
  // rail four ramps slowly so the pg-mode wait is visible
  tps_rail_model #(.PG_CYC(20)) rail_one_u (.core_clk(core_clk),
    .rst_n(rst_n), .enable(rail1_en), .power_good(pg1));
  tps_rail_model #(.PG_CYC(150)) rail_four_u (.core_clk(core_clk),
    .rst_n(rst_n), .enable(rail4_en), .power_good(pg4));

  always #4 core_clk = ~core_clk;

  task check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      final_report;
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    check("pready", pready, 1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic sig(input int s);
    case (s)
      0: return en1;
      1: return en4;
      default: return pg4;
    endcase
  endfunction : sig

  // counts edges until the chosen level is seen high
  task wait_hi(input int s);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sig(s) !== 1'b1 && n < 400);
  endtask : wait_hi

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    check("en1_idle", en1, 0);
    check("state_idle", seq_state, TPS_IDLE);
    check("step1_pin_idle", step1_pin, 0);
    apb(1'b0, `TPS_OFF_DELAY, 32'h0);
    check("delay_reset", r, 32'h6);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `TPS_OFF_DELAY, wr_v[i]);
      apb(1'b0, `TPS_OFF_DELAY, 32'h0);
      check("delay_clamp", r, ex_v[i]);
    end
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped_err", e, 1);
    // time mode, order pin held high as the board must
    rail_order_select <= 1'b1;
    seq_activate      <= 1'b1;
    wait_hi(0);
    check("en1_start", n <= 3, 1);
    check("en4_held", en4, 0);
    check("step2_pin_low", step2_pin, 0);
    check("soft_time", soft_ticks, 32'h6);
    wait_hi(1);
    check("time_gap", n >= 3 * 3 * TICK - 2 && n <= 3 * 3 * TICK + 4, 1);
    check("step2_pin_high", step2_pin, 1);
    check("step2_out_high", {s1_out, s2_out}, 2'h3);
    apb(1'b0, `TPS_OFF_STATUS, 32'h0);
    check("status_time", r[5:0], 6'h3F);
    seq_activate <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("en_drop", {en1, en4, s1_oe, s2_oe}, 4'h3);
    check("state_clear", seq_state, TPS_IDLE);
    // power-good mode, regulator four first, 4 ms delay
    mode_select       <= 1'b0;
    rail_order_select <= 1'b0;
    apb(1'b1, `TPS_OFF_DELAY, 32'h4);
    seq_activate <= 1'b1;
    wait_hi(1);
    check("en1_wait", en1, 0);
    check("soft_pg", soft_ticks, 32'hC);
    wait_hi(2);
    check("en1_before_pg", en1, 0);
    check("state_pg", seq_state, TPS_FIRST);
    wait_hi(0);
    check("pg_gap", n >= 3 * 4 * TICK - 2 && n <= 3 * 4 * TICK + 6, 1);
    apb(1'b0, `TPS_OFF_STATUS, 32'h0);
    check("status_pg", r[3:2], 2'h0);
    seq_activate <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("en_drop_pg", {en1, en4}, 2'h0);
    final_report;
  end
endmodule : two_rail_power_sequencer_tb_top
